/* hw/fssr_pkg.sv */
// Package: register map, field layout, modes and timing constants of the fan speed register bank
package fssr_pkg;
  // Command codes of the twelve registers
  localparam logic [7:0] CMD_SPEED  = 8'h00;
  localparam logic [7:0] CMD_CONFIG = 8'h02;
  localparam logic [7:0] CMD_PINDEF = 8'h04;
  localparam logic [7:0] CMD_DRIVE  = 8'h06;
  localparam logic [7:0] CMD_FLTEN  = 8'h08;
  localparam logic [7:0] CMD_FLTST  = 8'h0A;
  localparam logic [7:0] CMD_CNT0   = 8'h0C;
  localparam logic [7:0] CMD_CNT1   = 8'h0E;
  localparam logic [7:0] CMD_CNT2   = 8'h10;
  localparam logic [7:0] CMD_CNT3   = 8'h12;
  localparam logic [7:0] CMD_PINST  = 8'h14;
  localparam logic [7:0] CMD_WINDOW = 8'h16;
  // Reset values
  localparam logic [7:0] RST_SPEED  = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h0A;
  localparam logic [7:0] RST_PINDEF = 8'hFF;
  localparam logic [7:0] RST_DRIVE  = 8'h00;
  localparam logic [7:0] RST_FLTEN  = 8'h00;
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [7:0] RST_WINDOW = 8'h02;
  localparam logic [7:0] RST_CMDPTR = 8'h00;
  localparam logic [7:0] DRIVE_MAX  = 8'hFF;
  // Configuration fields
  typedef struct packed {
    logic [1:0] rsvd;
    logic [1:0] mode;
    logic       fan_voltage_select;
    logic [2:0] prescale_code;
  } fssr_cfg_s;
  localparam logic [1:0] MODE_FULL_ON = 2'h0;
  localparam logic [1:0] MODE_OFF     = 2'h1;
  localparam logic [1:0] MODE_CLOSED  = 2'h2;
  localparam logic [1:0] MODE_OPEN    = 2'h3;
  localparam logic [2:0] PRESCALE_MAX = 3'h4;
  // Pin function codes, two bits per pin on pins 0 to 2, one bit each on pins 3 and 4
  localparam logic [1:0] PIN_EXTCLK   = 2'h0;
  localparam logic [1:0] PIN_SPECIAL  = 2'h1;
  localparam logic [1:0] PIN_LOW      = 2'h2;
  localparam int         PIN_FULL_ON  = 1;
  localparam int         PIN_CLKSYNC  = 2;
  localparam int         PINS         = 5;
  localparam int         TACHS        = 4;
  // Timing
  localparam int CLK_FREQ_HZ        = 10_000_000;
  localparam int OSC_FREQ_HZ        = 254_000;
  localparam int OSC_DIV            = CLK_FREQ_HZ / OSC_FREQ_HZ;
  localparam int REF_SHIFT          = 7;
  localparam int MIN_TACH_PERIOD_US = 1000;
  localparam int MIN_TACH_REF       = (MIN_TACH_PERIOD_US * (OSC_FREQ_HZ / 1000) + 999) / 1000;
  localparam int WINDOW_UNIT_MS     = 250;
  localparam int WINDOW_UNIT_CYC    = WINDOW_UNIT_MS * (CLK_FREQ_HZ / 1000);
  // Serial slave states
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
  } fssr_state_e;
endpackage

/* hw/fssr_speed_loop.sv */
// Closed-loop speed regulator: compares tachometer period with setpoint reference period
`timescale 1ns/1ps
`default_nettype none
module fssr_speed_loop
  import fssr_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       enable_i,
  input  wire logic       ref_tick_i,
  input  wire logic       tach_edge_i,
  input  wire logic [7:0] setpoint_code_i,
  input  wire logic [2:0] prescale_code_i,
  output logic            step_up_o,
  output logic            step_down_o
);
  localparam logic [16:0] MIN_REF = 17'(MIN_TACH_REF);
  logic [2:0]  shift_d;
  logic [16:0] target_d;
  logic [17:0] period_q;

  always_comb begin
    shift_d  = (prescale_code_i > PRESCALE_MAX) ? PRESCALE_MAX : prescale_code_i;
    target_d = (({9'h000, setpoint_code_i} + 17'h00001) << REF_SHIFT) >> shift_d;
    if (target_d < MIN_REF) begin
      target_d = MIN_REF;
    end
  end

  // Period of one tachometer pulse, i.e. half a revolution, in reference ticks
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      period_q <= 18'h00000;
    end else if (tach_edge_i) begin
      period_q <= 18'h00000;
    end else if (ref_tick_i && period_q != 18'h3FFFF) begin
      period_q <= period_q + 18'h00001;
    end
  end

  // Too short a period means too fast: raise the drive code to slow the fan
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      step_up_o   <= 1'b0;
      step_down_o <= 1'b0;
    end else begin
      step_up_o   <= enable_i && tach_edge_i && (period_q < {1'b0, target_d});
      step_down_o <= enable_i && tach_edge_i && (period_q > {1'b0, target_d});
    end
  end
endmodule
`default_nettype wire

/* hw/fssr_top.sv */
// Top: two-wire slave, register bank, reference clock, pin functions and pulse counters
`timescale 1ns/1ps
`default_nettype none
module fssr_top
  import fssr_pkg::*;
#(
  parameter int WINDOW_UNIT = WINDOW_UNIT_CYC
)(
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire logic [6:0]       slave_addr_i,
  input  wire logic             scl_i,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe_n_o,
  input  wire logic             primary_pulse_input_i,
  input  wire logic [2:0]       monitor_pulse_i,
  input  wire logic [PINS-1:0]  gpio_i,
  output logic      [PINS-1:0]  gpio_o,
  output logic      [PINS-1:0]  gpio_oe_n_o,
  output logic      [7:0]       drive_level_o,
  output logic                  fan_voltage_select_o
);
  fssr_state_e state_q;
  logic [6:0]  addr_q;
  logic        scl_q;
  logic        sda_q;
  logic        start_d;
  logic        stop_d;
  logic        rise_d;
  logic        fall_d;
  logic [7:0]  shift_q;
  logic [7:0]  tx_q;
  logic [2:0]  bit_q;
  logic        byte_done_q;
  logic        rw_q;
  logic        sda_drive_q;
  logic        mack_q;
  logic [7:0]  cmd_ptr_q;
  logic        wr_en_d;
  logic [7:0]  rd_data_d;
  logic [7:0]  speed_setpoint_q;
  fssr_cfg_s   cfg_q;
  logic [7:0]  pin_def_q;
  logic [7:0]  drive_level_q;
  logic [7:0]  fault_enable_q;
  logic [7:0]  fault_status_q;
  logic [7:0]  count_window_q;
  logic [7:0]  pin_status_q;
  logic [7:0]  count_q [TACHS];
  logic [7:0]  live_q [TACHS];
  logic [TACHS-1:0] tach_q;
  logic [TACHS-1:0] tach_edge_d;
  logic [5:0]  osc_cnt_q;
  logic        osc_tick_d;
  logic        osc_out_q;
  logic        ext_clk_q;
  logic        ext_sel_d;
  logic        ref_tick_d;
  logic        closed_d;
  logic        step_up;
  logic        step_down;
  logic        full_on_pin_d;
  logic [31:0] win_cnt_q;
  logic [31:0] win_len_d;
  logic        win_end_d;

  // Strap address sampled whenever the slave is idle
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      addr_q <= 7'h00;
    end else if (state_q == ST_IDLE) begin
      addr_q <= slave_addr_i;
    end
  end

  // Bus edges and start/stop conditions
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end
  assign start_d = scl_i && scl_q && sda_q && !sda_i;
  assign stop_d  = scl_i && scl_q && !sda_q && sda_i;
  assign rise_d  = scl_i && !scl_q;
  assign fall_d  = !scl_i && scl_q;

  // Serial slave sequencer
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_q     <= ST_IDLE;
      shift_q     <= 8'h00;
      tx_q        <= 8'h00;
      bit_q       <= 3'h0;
      byte_done_q <= 1'b0;
      rw_q        <= 1'b0;
      sda_drive_q <= 1'b0;
      mack_q      <= 1'b1;
    end else if (start_d) begin
      state_q     <= ST_ADDR;
      bit_q       <= 3'h0;
      byte_done_q <= 1'b0;
      sda_drive_q <= 1'b0;
    end else if (stop_d) begin
      state_q     <= ST_IDLE;
      sda_drive_q <= 1'b0;
    end else if (rise_d) begin
      if (state_q == ST_ADDR || state_q == ST_CMD || state_q == ST_WR) begin
        shift_q <= {shift_q[6:0], sda_i};
        bit_q   <= bit_q + 3'h1;
        if (bit_q == 3'h7) begin
          byte_done_q <= 1'b1;
        end
      end else if (state_q == ST_RD_ACK) begin
        mack_q <= sda_i;
      end
    end else if (fall_d) begin
      case (state_q)
        ST_ADDR: begin
          if (byte_done_q) begin
            byte_done_q <= 1'b0;
            if (shift_q[7:1] == addr_q) begin
              rw_q        <= shift_q[0];
              sda_drive_q <= 1'b1;
              state_q     <= ST_ADDR_ACK;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (rw_q) begin
            tx_q        <= {rd_data_d[6:0], 1'b0};
            sda_drive_q <= !rd_data_d[7];
            bit_q       <= 3'h1;
            state_q     <= ST_RD;
          end else begin
            sda_drive_q <= 1'b0;
            state_q     <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (byte_done_q) begin
            byte_done_q <= 1'b0;
            sda_drive_q <= 1'b1;
            state_q     <= ST_CMD_ACK;
          end
        end
        ST_CMD_ACK: begin
          sda_drive_q <= 1'b0;
          state_q     <= ST_WR;
        end
        ST_WR: begin
          if (byte_done_q) begin
            byte_done_q <= 1'b0;
            sda_drive_q <= 1'b1;
            state_q     <= ST_WR_ACK;
          end
        end
        ST_WR_ACK: begin
          sda_drive_q <= 1'b0;
          state_q     <= ST_WR;
        end
        ST_RD: begin
          if (bit_q == 3'h0) begin
            sda_drive_q <= 1'b0;
            state_q     <= ST_RD_ACK;
          end else begin
            sda_drive_q <= !tx_q[7];
            tx_q        <= {tx_q[6:0], 1'b0};
            bit_q       <= bit_q + 3'h1;
          end
        end
        ST_RD_ACK: begin
          if (mack_q) begin
            state_q <= ST_IDLE;
          end else begin
            tx_q        <= {rd_data_d[6:0], 1'b0};
            sda_drive_q <= !rd_data_d[7];
            bit_q       <= 3'h1;
            state_q     <= ST_RD;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign sda_o      = 1'b0;
  assign sda_oe_n_o = !sda_drive_q;
  assign wr_en_d    = fall_d && !start_d && !stop_d && state_q == ST_WR && byte_done_q;

  // Command pointer
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_ptr_q <= RST_CMDPTR;
    end else if (fall_d && !start_d && !stop_d && state_q == ST_CMD && byte_done_q) begin
      cmd_ptr_q <= shift_q;
    end
  end

  // Writable registers; read-only codes fall through untouched
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      speed_setpoint_q <= RST_SPEED;
      cfg_q            <= RST_CONFIG;
      pin_def_q        <= RST_PINDEF;
      fault_enable_q   <= RST_FLTEN;
      count_window_q   <= RST_WINDOW;
    end else if (wr_en_d) begin
      if (cmd_ptr_q == CMD_SPEED) begin
        speed_setpoint_q <= shift_q;
      end else if (cmd_ptr_q == CMD_CONFIG) begin
        cfg_q <= {2'h0, shift_q[5:0]};
      end else if (cmd_ptr_q == CMD_PINDEF) begin
        pin_def_q <= shift_q;
      end else if (cmd_ptr_q == CMD_FLTEN) begin
        fault_enable_q <= shift_q;
      end else if (cmd_ptr_q == CMD_WINDOW) begin
        count_window_q <= shift_q;
      end
    end
  end

  // Drive level: host writes it, the regulator steps it in closed-loop mode
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      drive_level_q <= RST_DRIVE;
    end else if (wr_en_d && cmd_ptr_q == CMD_DRIVE) begin
      drive_level_q <= shift_q;
    end else if (step_up && drive_level_q != DRIVE_MAX) begin
      drive_level_q <= drive_level_q + 8'h01;
    end else if (step_down && drive_level_q != RST_DRIVE) begin
      drive_level_q <= drive_level_q - 8'h01;
    end
  end

  // Read multiplexer
  always_comb begin
    if (cmd_ptr_q == CMD_SPEED) begin
      rd_data_d = speed_setpoint_q;
    end else if (cmd_ptr_q == CMD_CONFIG) begin
      rd_data_d = cfg_q;
    end else if (cmd_ptr_q == CMD_PINDEF) begin
      rd_data_d = pin_def_q;
    end else if (cmd_ptr_q == CMD_DRIVE) begin
      rd_data_d = drive_level_q;
    end else if (cmd_ptr_q == CMD_FLTEN) begin
      rd_data_d = fault_enable_q;
    end else if (cmd_ptr_q == CMD_FLTST) begin
      rd_data_d = fault_status_q;
    end else if (cmd_ptr_q == CMD_CNT0) begin
      rd_data_d = count_q[0];
    end else if (cmd_ptr_q == CMD_CNT1) begin
      rd_data_d = count_q[1];
    end else if (cmd_ptr_q == CMD_CNT2) begin
      rd_data_d = count_q[2];
    end else if (cmd_ptr_q == CMD_CNT3) begin
      rd_data_d = count_q[3];
    end else if (cmd_ptr_q == CMD_PINST) begin
      rd_data_d = pin_status_q;
    end else if (cmd_ptr_q == CMD_WINDOW) begin
      rd_data_d = count_window_q;
    end else begin
      rd_data_d = RST_ZERO;
    end
  end

  // Fault detection is outside this block; status stays clear
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      fault_status_q <= RST_ZERO;
    end else begin
      fault_status_q <= RST_ZERO;
    end
  end

  // Pin levels seen by software
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pin_status_q <= {3'h0, {PINS{1'b1}}};
    end else begin
      pin_status_q <= {3'h0, gpio_i};
    end
  end

  // Internal oscillator as an enable pulse
  assign osc_tick_d = (osc_cnt_q == 6'(OSC_DIV - 1));
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      osc_cnt_q <= 6'h00;
      osc_out_q <= 1'b0;
    end else if (osc_tick_d) begin
      osc_cnt_q <= 6'h00;
      osc_out_q <= !osc_out_q;
    end else begin
      osc_cnt_q <= osc_cnt_q + 6'h01;
    end
  end

  // External reference on the clock sync pin
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ext_clk_q <= 1'b0;
    end else begin
      ext_clk_q <= gpio_i[PIN_CLKSYNC];
    end
  end
  assign ext_sel_d  = pin_def_q[2*PIN_CLKSYNC +: 2] == PIN_EXTCLK;
  assign ref_tick_d = ext_sel_d ? (gpio_i[PIN_CLKSYNC] && !ext_clk_q) : osc_tick_d;

  // Pin drivers: open drain, low code pulls low, clock output toggles
  genvar p;
  generate
    for (p = 0; p < PINS; p++) begin : g_pin
      logic [1:0] code;
      logic       low;
      if (p < 3) begin : g_dual
        assign code = pin_def_q[2*p +: 2];
      end else begin : g_single
        assign code = {1'b1, pin_def_q[p+3]};
      end
      if (p == PIN_CLKSYNC) begin : g_clk
        assign low = (code == PIN_LOW) || (code == PIN_SPECIAL && !osc_out_q);
      end else begin : g_plain
        assign low = (code == PIN_LOW);
      end
      assign gpio_o[p]      = 1'b0;
      assign gpio_oe_n_o[p] = !low;
    end
  endgenerate

  assign full_on_pin_d = pin_def_q[2*PIN_FULL_ON +: 2] == PIN_SPECIAL && !gpio_i[PIN_FULL_ON];
  assign closed_d      = cfg_q.mode == MODE_CLOSED && !full_on_pin_d;

  // Applied drive code: low code gives full voltage across the fan
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      drive_level_o        <= RST_DRIVE;
      fan_voltage_select_o <= RST_CONFIG[3];
    end else begin
      fan_voltage_select_o <= cfg_q.fan_voltage_select;
      if (full_on_pin_d || cfg_q.mode == MODE_FULL_ON) begin
        drive_level_o <= RST_DRIVE;
      end else if (cfg_q.mode == MODE_OFF) begin
        drive_level_o <= DRIVE_MAX;
      end else begin
        drive_level_o <= drive_level_q;
      end
    end
  end

  fssr_speed_loop u_loop (
    .clk_sys_i       (clk_sys_i),
    .rst_i           (rst_i),
    .enable_i        (closed_d),
    .ref_tick_i      (ref_tick_d),
    .tach_edge_i     (tach_edge_d[0]),
    .setpoint_code_i (speed_setpoint_q),
    .prescale_code_i (cfg_q.prescale_code),
    .step_up_o       (step_up),
    .step_down_o     (step_down)
  );

  // Counting window of (code+1) units
  assign win_len_d = ({24'h000000, count_window_q} + 32'h1) * 32'(WINDOW_UNIT);
  assign win_end_d = (win_cnt_q + 32'h1) >= win_len_d;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      win_cnt_q <= 32'h0;
    end else if (win_end_d) begin
      win_cnt_q <= 32'h0;
    end else begin
      win_cnt_q <= win_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tach_q <= '0;
    end else begin
      tach_q <= {monitor_pulse_i, primary_pulse_input_i};
    end
  end
  assign tach_edge_d = {monitor_pulse_i, primary_pulse_input_i} & ~tach_q;

  // Pulse counters, saturating, published at each window end
  genvar t;
  generate
    for (t = 0; t < TACHS; t++) begin : g_tach
      always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
          live_q[t]  <= RST_ZERO;
          count_q[t] <= RST_ZERO;
        end else if (win_end_d) begin
          count_q[t] <= live_q[t];
          live_q[t]  <= RST_ZERO;
        end else if (tach_edge_d[t] && live_q[t] != DRIVE_MAX) begin
          live_q[t] <= live_q[t] + 8'h01;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* sim/fssr_top_sva.sv */
// Checker for the serial port and drive outputs of the fan register bank
`timescale 1ns/1ps
`default_nettype none
module fssr_top_sva
  import fssr_pkg::*;
#(
  parameter int WINDOW_UNIT = WINDOW_UNIT_CYC
)(
  input wire logic            clk_sys_i,
  input wire logic            rst_i,
  input wire logic            scl_i,
  input wire logic            sda_o,
  input wire logic            sda_oe_n_o,
  input wire logic [PINS-1:0] gpio_o,
  input wire logic [7:0]      drive_level_o,
  input wire logic            fan_voltage_select_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sda_zero_a: assert property (sda_o == 1'h0)
    else $error("sda data value not low");
  gpio_zero_a: assert property (gpio_o == '0)
    else $error("gpio data value not low");
  ack_launch_a: assert property ($fell(sda_oe_n_o) |-> $past(scl_i, 2) && !$past(scl_i))
    else $error("sda pulled low without a seen scl fall");
  ack_release_a: assert property ($rose(sda_oe_n_o) |->
    ($past(scl_i, 2) && !$past(scl_i)) || $past(scl_i))
    else $error("sda released at the wrong moment");
  sda_quiet_a: assert property (scl_i && $past(scl_i) && $past(scl_i, 2) |->
    $stable(sda_oe_n_o))
    else $error("sda moved while scl high");
  bus_idle_a: assert property (scl_i [*8] |-> sda_oe_n_o)
    else $error("sda held low on an idle bus");
  volt_change_a: assert property ($changed(fan_voltage_select_o) |->
    ($past(scl_i, 2) && !$past(scl_i)) || ($past(scl_i, 3) && !$past(scl_i, 2)))
    else $error("voltage select changed outside a write");
  reset_vals_a: assert property ($fell(rst_i) |->
    drive_level_o == 8'h00 && fan_voltage_select_o && sda_oe_n_o)
    else $error("wrong output values after reset");
endmodule
bind fssr_top fssr_top_sva #(.WINDOW_UNIT(WINDOW_UNIT)) u_fssr_top_sva (
  .clk_sys_i            (clk_sys_i),
  .rst_i                (rst_i),
  .scl_i                (scl_i),
  .sda_o                (sda_o),
  .sda_oe_n_o           (sda_oe_n_o),
  .gpio_o               (gpio_o),
  .drive_level_o        (drive_level_o),
  .fan_voltage_select_o (fan_voltage_select_o)
);
`default_nettype wire

/* sim/fssr_host.sv */
// Two-wire bus master model issuing write, read and receive transfers
`timescale 1ns/1ps
`default_nettype none
module fssr_host (
  input  wire logic clk_sys_i,
  input  wire logic sda_i,
  output var logic  scl_o,
  output var logic  sda_o
);
  initial begin
    scl_o = 1'h1;
    sda_o = 1'h1;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // Data moves only while SCL is low, sampled in mid-high
  task automatic bx(input logic b, output logic r);
    tk(1);
    sda_o <= b;
    tk(3);
    scl_o <= 1'h1;
    tk(2);
    r = sda_i;
    tk(2);
    scl_o <= 1'h0;
  endtask
  task automatic by(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bx(d[i], q[i]);
    bx(m, a);
  endtask
  task automatic sr;
    tk(1);
    sda_o <= 1'h1;
    tk(3);
    scl_o <= 1'h1;
    tk(4);
    sda_o <= 1'h0;
    tk(4);
    scl_o <= 1'h0;
  endtask
  task automatic sp;
    tk(1);
    sda_o <= 1'h0;
    tk(3);
    scl_o <= 1'h1;
    tk(4);
    sda_o <= 1'h1;
    tk(8);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] c, d, output logic n);
    logic [7:0] q;
    logic       k0, k1, k2;
    sr;
    by({a, 1'h0}, 1'h1, q, k0);
    by(c, 1'h1, q, k1);
    by(d, 1'h1, q, k2);
    sp;
    n = k0 | k1 | k2;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] c, input logic sh,
                    output logic [7:0] d, output logic n);
    logic [7:0] q;
    logic       k0, k1, k2, k3;
    k0 = 1'h0;
    k1 = 1'h0;
    if (!sh) begin
      sr;
      by({a, 1'h0}, 1'h1, q, k0);
      by(c, 1'h1, q, k1);
    end
    sr;
    by({a, 1'h1}, 1'h1, q, k2);
    by(8'hFF, 1'h1, d, k3);
    sp;
    n = k0 | k1 | k2;
  endtask
endmodule
`default_nettype wire

/* sim/fssr_top_tb_top.sv */
// Self-checking bench of the fan register bank
`timescale 1ns/1ps
`default_nettype none
module fssr_top_tb_top
  import fssr_pkg::*;
;
  localparam int         WU   = 50;
  localparam logic [6:0] ADDR = 7'h4B;
  localparam logic [7:0] RV [12] = '{RST_SPEED, RST_CONFIG, RST_PINDEF, RST_DRIVE, RST_FLTEN,
    RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, 8'h1F, RST_WINDOW};
  localparam logic [7:0] RWC [6] = '{CMD_SPEED, CMD_CONFIG, CMD_PINDEF, CMD_DRIVE, CMD_FLTEN,
    CMD_WINDOW};
  logic            clk_sys_i = 1'h0;
  logic            rst_i     = 1'h1;
  logic            tach_q    = 1'h0;
  logic [2:0]      mon_q     = 3'h0;
  logic [PINS-1:0] gext_q    = 5'h1F;
  logic            ext_on    = 1'h0;
  logic            ext_tg    = 1'h0;
  logic [31:0]     seed;
  int              bad_count = 0;
  int              compares  = 0;
  logic            scl, sda_m, sda_d, sda_oe_n, fvs;
  logic [PINS-1:0] gpio_d, gpio_oe_n;
  logic [7:0]      drv;
  wire logic       sda_w = sda_m & (sda_oe_n | sda_d);
  wire logic [PINS-1:0] gpio_w = (gext_q ^ {2'h0, ext_tg, 2'h0}) & (gpio_oe_n | gpio_d);
  always #50 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (ext_on) ext_tg <= ~ext_tg;
  fssr_host u_fssr_host (.clk_sys_i(clk_sys_i), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));
  fssr_top #(.WINDOW_UNIT(WU)) u_fssr_top (
    .clk_sys_i             (clk_sys_i),
    .rst_i                 (rst_i),
    .slave_addr_i          (ADDR),
    .scl_i                 (scl),
    .sda_i                 (sda_w),
    .sda_o                 (sda_d),
    .sda_oe_n_o            (sda_oe_n),
    .primary_pulse_input_i (tach_q),
    .monitor_pulse_i       (mon_q),
    .gpio_i                (gpio_w),
    .gpio_o                (gpio_d),
    .gpio_oe_n_o           (gpio_oe_n),
    .drive_level_o         (drv),
    .fan_voltage_select_o  (fvs)
  );
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] wexp(input logic [7:0] c, v);
    return (c == CMD_CONFIG) ? (v & 8'h3F) : v;
  endfunction
  function automatic logic [7:0] mode_drv(input logic [1:0] m, input logic [7:0] d);
    return (m == MODE_FULL_ON) ? 8'h00 : ((m == MODE_OFF) ? 8'hFF : d);
  endfunction
  task automatic chk(input logic [7:0] s, e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic close_out;
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic w(input logic [7:0] c, d);
    logic n;
    u_fssr_host.wr(ADDR, c, d, n);
    chk({7'h00, n}, 8'h00);
  endtask
  task automatic r(input logic [7:0] c, input logic sh, input logic [7:0] e);
    logic       n;
    logic [7:0] q;
    u_fssr_host.rd(ADDR, c, sh, q, n);
    chk({7'h00, n}, 8'h00);
    chk(q, e);
  endtask
  // Tachometer pulses 400 us apart, faster than the internal reference period
  task automatic pulses(input int n);
    repeat (n) begin
      tach_q <= 1'h1;
      mon_q  <= 3'h7;
      repeat (2000) @(posedge clk_sys_i);
      tach_q <= 1'h0;
      mon_q  <= 3'h0;
      repeat (2000) @(posedge clk_sys_i);
    end
    repeat (4) @(posedge clk_sys_i);
  endtask
  initial begin
    repeat (90000) @(posedge clk_sys_i);
    bad_count++;
    close_out;
  end
  initial begin
    logic [7:0] v;
    logic       n;
    seed = 32'h716D7A3A;
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    repeat (4) @(posedge clk_sys_i);
    r(CMD_SPEED, 1'h1, RST_SPEED);
    for (int i = 0; i < 12; i++) r(8'(2 * i), 1'h0, RV[i]);
    for (int i = 5; i < 11; i++) begin
      w(8'(2 * i), 8'h5A);
      r(8'(2 * i), 1'h0, RV[i]);
    end
    w(8'h18, 8'h33);
    r(8'h18, 1'h0, 8'h00);
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      v = (k == 0) ? 8'hFF : seed[7:0];
      w(RWC[k], v);
      r(RWC[k], 1'h0, wexp(RWC[k], v));
      r(8'h00, 1'h1, wexp(RWC[k], v));
    end
    w(CMD_PINDEF, 8'hFF);
    seed = lfsr(seed);
    gext_q <= seed[4:0];
    repeat (4) @(posedge clk_sys_i);
    r(CMD_PINST, 1'h0, {3'h0, gext_q});
    // Every pin set to pull low
    w(CMD_PINDEF, 8'h2A);
    repeat (4) @(posedge clk_sys_i);
    chk({3'h0, gpio_oe_n}, 8'h00);
    r(CMD_PINST, 1'h0, 8'h00);
    u_fssr_host.wr(ADDR ^ 7'h01, CMD_SPEED, 8'h11, n);
    chk({7'h00, n}, 8'h01);
    r(CMD_SPEED, 1'h0, 8'hFF);
    w(CMD_DRIVE, 8'h5A);
    for (int m = 0; m < 4; m++) begin
      w(CMD_CONFIG, {2'h0, 2'(m), 1'h0, 3'h2});
      repeat (4) @(posedge clk_sys_i);
      chk(drv, mode_drv(2'(m), 8'h5A));
      chk({7'h00, fvs}, 8'h00);
    end
    w(CMD_SPEED, 8'h1F);
    w(CMD_CONFIG, 8'h2C);
    w(CMD_DRIVE, 8'h80);
    chk({7'h00, fvs}, 8'h01);
    pulses(4);
    chk({7'h00, drv > 8'h80 && drv <= 8'h84}, 8'h01);
    ext_on <= 1'h1;
    w(CMD_PINDEF, 8'hCF);
    w(CMD_DRIVE, 8'h80);
    pulses(4);
    chk({7'h00, drv < 8'h80 && drv >= 8'h7C}, 8'h01);
    ext_on <= 1'h0;
    w(CMD_PINDEF, 8'hFF);
    w(CMD_CONFIG, 8'h3C);
    w(CMD_DRIVE, 8'h80);
    pulses(4);
    chk(drv, 8'h80);
    close_out;
  end
endmodule
`default_nettype wire
